// file: lsfa_params.svh
// Register map, field positions, reset values and counts of the light sensor flag block.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
// What this block does
// - Overflow bit follows each finished measurement
// - Manual range may flag transient overload
// - Auto range flags overflow only at top
// - Auto range escalates and restarts on overload
// - Sample done set when conversion finishes
// - Config read or non-shutdown write clears done
// - Shutdown write leaves sample done alone
// - Over-threshold flag after enough consecutive exceedances
// - Under-threshold flag after enough consecutive shortfalls
// - Latch off: flags and alert track comparison
// - Latch on: hold until config read clears
// - Polarity zero drives alert low when active
// - Polarity one releases alert when active
// - Exponent zeroing blanks reported exponent manually
// - Limit comparisons use unmasked result
// - Persistence field selects one, two, four, eight
// - Range code twelve selects automatic ranging
// - Mode selects shutdown, single, continuous; single self-clears
// - Entering shutdown keeps flags and alert
`ifndef LSFA_PARAMS_SVH
`define LSFA_PARAMS_SVH
// Register indexes; the byte address is four times the index.
`define LSFA_IDX_RESULT 4'h0
`define LSFA_IDX_CONFIG 4'h1
`define LSFA_IDX_LOW 4'h2
`define LSFA_IDX_HIGH 4'h3
// Configuration field positions.
`define LSFA_F_RANGE 15:12
`define LSFA_F_CTIME 11
`define LSFA_F_MODE 10:9
`define LSFA_F_OVR 8
`define LSFA_F_DONE 7
`define LSFA_F_OVER 6
`define LSFA_F_UNDER 5
`define LSFA_F_LATCH 4
`define LSFA_F_POL 3
`define LSFA_F_ZERO 2
`define LSFA_F_PERSIST 1:0
// Reset values.
`define LSFA_RST_RANGE 4'hC
`define LSFA_RST_CTIME 1'b1
`define LSFA_RST_MODE 2'h0
`define LSFA_RST_LATCH 1'b1
`define LSFA_RST_LOW 16'h0000
`define LSFA_RST_HIGH 16'hBFFF
// Range codes and mode codes.
`define LSFA_RANGE_AUTO 4'hC
`define LSFA_RANGE_MIN 4'h0
`define LSFA_RANGE_MAX 4'hB
`define LSFA_MODE_OFF 2'h0
`define LSFA_MODE_SINGLE 2'h1
// Saturation of the consecutive fault counters.
`define LSFA_FAULT_SAT 4'h8
`endif

// file: lsfa_pkg.sv
// Types shared by the light sensor flag block.
// Assumes nothing beyond a SystemVerilog elaborator.
package lsfa_pkg;
  typedef enum logic [1:0] {
    LSFA_IDLE = 2'b00,
    LSFA_START = 2'b01,
    LSFA_WAIT = 2'b11
  } lsfa_state_e;
endpackage

// file: lsfa_flags.sv
// Status, ranging and alert logic of an optical power sensor with an AHB-Lite register port.
// Assumes a conversion core that answers each conv_start with one conv_done pulse.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "lsfa_params.svh"
module lsfa_flags #(
  parameter int MANT_W = 12
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic conv_start,
  output logic [3:0] conv_range,
  output logic conv_long,
  input wire logic conv_done,
  input wire logic [MANT_W-1:0] conv_mantissa,
  input wire logic conv_overload,
  output logic alert_out,
  output logic alert_oe
);
  if (MANT_W != 12)
  begin : g_chk
    $error("Mantissa width must be 12.");
  end

  // Optical power as mantissa shifted by exponent, so limits with other exponents compare right.
  function automatic logic [26:0] to_power(input logic [15:0] v);
    to_power = {15'h0000, v[11:0]} << v[15:12];
  endfunction

  function automatic logic [3:0] fault_need(input logic [1:0] fc);
    unique case (fc)
      2'b00: fault_need = 4'h1;
      2'b01: fault_need = 4'h2;
      2'b10: fault_need = 4'h4;
      2'b11: fault_need = 4'h8;
    endcase
  endfunction

  function automatic logic [3:0] fault_step(input logic viol, input logic [3:0] cnt);
    if (!viol)
      fault_step = 4'h0;
    else if (cnt == `LSFA_FAULT_SAT)
      fault_step = cnt;
    else
      fault_step = cnt + 4'h1;
  endfunction

  // Bus group.
  logic wr_pend_reg, wr_pend_next;
  logic [3:0] idx_reg, idx_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic acc, rd_cfg, wr_cfg;
  logic [3:0] acc_idx;
  logic [15:0] cfg_view, result_view, wdat;

  // Sensor group.
  lsfa_pkg::lsfa_state_e state_reg, state_next;
  logic [3:0] range_reg, range_next, crange_reg, crange_next;
  logic ctime_reg, ctime_next, latch_reg, latch_next, pol_reg, pol_next;
  logic zero_reg, zero_next, ovr_reg, ovr_next, done_reg, done_next;
  logic over_reg, over_next, under_reg, under_next, start_reg, start_next;
  logic oe_reg, oe_next;
  logic [1:0] mode_reg, mode_next, persist_reg, persist_next;
  logic [15:0] result_reg, result_next, low_reg, low_next, high_reg, high_next;
  logic [3:0] hcnt_reg, hcnt_next, lcnt_reg, lcnt_next;
  logic auto_mode, meas_end, escalate, hi_hit, lo_hit;
  logic [15:0] raw;

  assign acc = hsel && hready && htrans[1] && (hsize == 3'b010);
  assign acc_idx = (haddr[31:6] == 26'h0) ? haddr[5:2] : 4'hF;
  assign rd_cfg = acc && !hwrite && (acc_idx == `LSFA_IDX_CONFIG);
  assign wr_cfg = wr_pend_reg && (idx_reg == `LSFA_IDX_CONFIG);
  assign wdat = hwdata[15:0];

  always_comb
  begin
    cfg_view = 16'h0000;
    cfg_view[`LSFA_F_RANGE] = range_reg;
    cfg_view[`LSFA_F_CTIME] = ctime_reg;
    cfg_view[`LSFA_F_MODE] = mode_reg;
    cfg_view[`LSFA_F_OVR] = ovr_reg;
    cfg_view[`LSFA_F_DONE] = done_reg;
    cfg_view[`LSFA_F_OVER] = over_reg;
    cfg_view[`LSFA_F_UNDER] = under_reg;
    cfg_view[`LSFA_F_LATCH] = latch_reg;
    cfg_view[`LSFA_F_POL] = pol_reg;
    cfg_view[`LSFA_F_ZERO] = zero_reg;
    cfg_view[`LSFA_F_PERSIST] = persist_reg;
    result_view = result_reg;
    if (zero_reg && range_reg < `LSFA_RANGE_AUTO)
      result_view[15:12] = 4'h0;
  end

  // Zero wait states: read data is fetched at the address phase and stands in the data phase.
  always_comb
  begin
    wr_pend_next = acc && hwrite;
    idx_next = acc ? acc_idx : idx_reg;
    hrdata_next = hrdata_reg;
    if (acc && !hwrite)
    begin
      unique case (acc_idx)
        `LSFA_IDX_RESULT: hrdata_next = {16'h0000, result_view};
        `LSFA_IDX_CONFIG: hrdata_next = {16'h0000, cfg_view};
        `LSFA_IDX_LOW: hrdata_next = {16'h0000, low_reg};
        `LSFA_IDX_HIGH: hrdata_next = {16'h0000, high_reg};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      wr_pend_reg <= 1'b0;
      idx_reg <= 4'h0;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      idx_reg <= idx_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign auto_mode = (range_reg == `LSFA_RANGE_AUTO);
  assign raw = {crange_reg, conv_mantissa};
  assign escalate = (state_reg == lsfa_pkg::LSFA_WAIT) && conv_done && auto_mode &&
    conv_overload && (crange_reg < `LSFA_RANGE_MAX);
  assign meas_end = (state_reg == lsfa_pkg::LSFA_WAIT) && conv_done && !escalate;
  // Limits compare against the raw exponent, never the zeroed one.
  assign hi_hit = fault_step(to_power(raw) > to_power(high_reg), hcnt_reg)
    >= fault_need(persist_reg);
  assign lo_hit = fault_step(to_power(raw) < to_power(low_reg), lcnt_reg)
    >= fault_need(persist_reg);

  always_comb
  begin
    state_next = state_reg;
    range_next = range_reg;
    ctime_next = ctime_reg;
    mode_next = mode_reg;
    latch_next = latch_reg;
    pol_next = pol_reg;
    zero_next = zero_reg;
    persist_next = persist_reg;
    crange_next = crange_reg;
    ovr_next = ovr_reg;
    done_next = done_reg;
    over_next = over_reg;
    under_next = under_reg;
    result_next = result_reg;
    low_next = low_reg;
    high_next = high_reg;
    hcnt_next = hcnt_reg;
    lcnt_next = lcnt_reg;
    start_next = 1'b0;
    // Clearing events come first so that a finishing measurement below wins.
    if (rd_cfg)
    begin
      done_next = 1'b0;
      if (latch_reg)
      begin
        over_next = 1'b0;
        under_next = 1'b0;
      end
    end
    if (wr_pend_reg && idx_reg == `LSFA_IDX_LOW)
      low_next = wdat;
    if (wr_pend_reg && idx_reg == `LSFA_IDX_HIGH)
      high_next = wdat;
    // Status bits in the written word are dropped.
    if (wr_cfg)
    begin
      range_next = wdat[`LSFA_F_RANGE];
      ctime_next = wdat[`LSFA_F_CTIME];
      mode_next = wdat[`LSFA_F_MODE];
      latch_next = wdat[`LSFA_F_LATCH];
      pol_next = wdat[`LSFA_F_POL];
      zero_next = wdat[`LSFA_F_ZERO];
      persist_next = wdat[`LSFA_F_PERSIST];
      if (wdat[`LSFA_F_MODE] != `LSFA_MODE_OFF)
        done_next = 1'b0;
    end
    unique case (state_reg)
      lsfa_pkg::LSFA_IDLE:
        if (mode_reg != `LSFA_MODE_OFF)
        begin
          state_next = lsfa_pkg::LSFA_START;
          crange_next = auto_mode ? `LSFA_RANGE_MIN : range_reg;
        end
      lsfa_pkg::LSFA_START:
      begin
        start_next = 1'b1;
        state_next = lsfa_pkg::LSFA_WAIT;
      end
      lsfa_pkg::LSFA_WAIT:
        if (escalate)
        begin
          crange_next = crange_reg + 4'h1;
          state_next = lsfa_pkg::LSFA_START;
        end
        else if (meas_end)
        begin
          ovr_next = conv_overload;
          done_next = 1'b1;
          result_next = raw;
          hcnt_next = fault_step(to_power(raw) > to_power(high_reg), hcnt_reg);
          lcnt_next = fault_step(to_power(raw) < to_power(low_reg), lcnt_reg);
          if (latch_reg)
          begin
            over_next = over_next | hi_hit;
            under_next = under_next | lo_hit;
          end
          else
          begin
            over_next = hi_hit;
            under_next = lo_hit;
          end
          if (mode_reg == `LSFA_MODE_SINGLE)
          begin
            mode_next = `LSFA_MODE_OFF;
            state_next = lsfa_pkg::LSFA_IDLE;
          end
          else
            state_next = lsfa_pkg::LSFA_START;
        end
    endcase
    // Shutdown abandons a conversion but leaves every flag and the pin as they stand.
    if (wr_cfg && wdat[`LSFA_F_MODE] == `LSFA_MODE_OFF)
      state_next = lsfa_pkg::LSFA_IDLE;
    else if (wr_cfg && state_reg == lsfa_pkg::LSFA_IDLE)
      state_next = lsfa_pkg::LSFA_IDLE;
    // Open drain: polarity zero pulls low when active, polarity one pulls low when quiet.
    oe_next = pol_next ? !(over_next | under_next) : (over_next | under_next);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= lsfa_pkg::LSFA_IDLE;
      range_reg <= `LSFA_RST_RANGE;
      ctime_reg <= `LSFA_RST_CTIME;
      mode_reg <= `LSFA_RST_MODE;
      latch_reg <= `LSFA_RST_LATCH;
      pol_reg <= 1'b0;
      zero_reg <= 1'b0;
      persist_reg <= 2'h0;
      crange_reg <= `LSFA_RANGE_MIN;
      ovr_reg <= 1'b0;
      done_reg <= 1'b0;
      over_reg <= 1'b0;
      under_reg <= 1'b0;
      result_reg <= 16'h0000;
      low_reg <= `LSFA_RST_LOW;
      high_reg <= `LSFA_RST_HIGH;
      hcnt_reg <= 4'h0;
      lcnt_reg <= 4'h0;
      start_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      range_reg <= range_next;
      ctime_reg <= ctime_next;
      mode_reg <= mode_next;
      latch_reg <= latch_next;
      pol_reg <= pol_next;
      zero_reg <= zero_next;
      persist_reg <= persist_next;
      crange_reg <= crange_next;
      ovr_reg <= ovr_next;
      done_reg <= done_next;
      over_reg <= over_next;
      under_reg <= under_next;
      result_reg <= result_next;
      low_reg <= low_next;
      high_reg <= high_next;
      hcnt_reg <= hcnt_next;
      lcnt_reg <= lcnt_next;
      start_reg <= start_next;
      oe_reg <= oe_next;
    end
  end

  // Bus answers and pin level are fixed flops; only the enable moves.
  always_ff @(posedge ref_clk)
  begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
    alert_out <= 1'b0;
  end

  assign hrdata = hrdata_reg;
  assign conv_start = start_reg;
  assign conv_range = crange_reg;
  assign conv_long = ctime_reg;
  assign alert_oe = oe_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  done_set_a: assert property (meas_end |=> done_reg)
    else $error("Sample done not set after a measurement.");
  read_clear_a: assert property (rd_cfg && !meas_end |=> !done_reg)
    else $error("Config read did not clear sample done.");
  off_keep_a: assert property (wr_cfg && wdat[10:9] == 2'h0 && !rd_cfg && !meas_end
    |=> done_reg == $past(done_reg))
    else $error("Shutdown write changed sample done.");
  range_step_a: assert property (escalate && !wr_cfg |=>
    state_reg == lsfa_pkg::LSFA_START && crange_reg == $past(crange_reg) + 4'h1)
    else $error("Range did not step up on overload.");
  low_drive_a: assert property (!pol_reg && (over_reg || under_reg) |-> alert_oe)
    else $error("Alert not pulled low while active.");
  high_release_a: assert property (pol_reg && (over_reg || under_reg) |-> !alert_oe)
    else $error("Alert not released while active.");
  exp_zero_a: assert property (acc && !hwrite && acc_idx == 4'h0 && zero_reg
    && range_reg < 4'hC |=> hrdata[15:12] == 4'h0)
    else $error("Exponent not zeroed on result read.");
  single_end_a: assert property (meas_end && mode_reg == 2'h1 && !wr_cfg
    |=> mode_reg == 2'h0 ##1 !conv_start)
    else $error("Single shot did not return to shutdown.");
  track_a: assert property (meas_end && !latch_reg |=> over_reg == $past(hi_hit)
    && under_reg == $past(lo_hit))
    else $error("Transparent flags do not follow comparison.");
  hold_a: assert property (over_reg && latch_reg && !rd_cfg |=> over_reg)
    else $error("Latched flag dropped without a clear.");
endmodule

// file: lsfa_core_model.sv
// Behavioural conversion core facing the flag block's conversion link.
// Assumes the flag block starts a conversion only while none is running.
`timescale 1ns/1ps
module lsfa_core_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic [3:0] conv_range,
  input wire logic [7:0] lat,
  input wire logic [11:0] mant,
  input wire logic [3:0] ovl_below,
  output logic conv_done,
  output logic [11:0] conv_mantissa,
  output logic conv_overload
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  // Outside the done pulse the data lines toggle, so a stale sample is caught.
  always_ff @(posedge ref_clk)
  begin
    conv_done <= 1'b0;
    conv_mantissa <= ~conv_mantissa;
    conv_overload <= ~conv_overload;
    if (!reset_n)
    begin
      busy_reg <= 1'b0;
      conv_mantissa <= 12'h000;
      conv_overload <= 1'b0;
    end
    else if (conv_start)
    begin
      busy_reg <= 1'b1;
      cnt_reg <= lat;
    end
    else if (busy_reg && cnt_reg == 8'h00)
    begin
      busy_reg <= 1'b0;
      conv_done <= 1'b1;
      conv_mantissa <= mant;
      conv_overload <= (conv_range < ovl_below);
    end
    else if (busy_reg)
      cnt_reg <= cnt_reg - 8'h01;
  end
endmodule

// file: tb_top.sv
// Self-checking bench for the light sensor flag block.
// Assumes a zero-wait AHB-Lite slave and the behavioural conversion core.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, conv_start, conv_long;
  logic conv_done, conv_overload, alert_out, alert_oe, hr_q, auto;
  logic fin_q = 1'b0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, rd_q;
  logic [3:0] conv_range, ovb;
  logic [11:0] conv_mantissa, mant;
  logic [7:0] lat;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int starts = 0;
  assign hready = hreadyout;
  lsfa_flags #(.MANT_W(12)) lsfa_flags_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conv_start(conv_start), .conv_range(conv_range),
    .conv_long(conv_long), .conv_done(conv_done), .conv_mantissa(conv_mantissa),
    .conv_overload(conv_overload), .alert_out(alert_out), .alert_oe(alert_oe));
  lsfa_core_model lsfa_core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .conv_start(conv_start), .conv_range(conv_range), .lat(lat), .mant(mant),
    .ovl_below(ovb), .conv_done(conv_done), .conv_mantissa(conv_mantissa),
    .conv_overload(conv_overload));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Sampling through flops keeps bus answers free of edge races.
  always @(posedge ref_clk)
  begin
    hr_q <= hreadyout;
    rd_q <= hrdata;
    fin_q <= conv_done && (!conv_overload || conv_range == 4'hB || !auto);
    if (conv_start === 1'b1)
      starts <= starts + 1;
    cycles <= cycles + 1;
  end
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_rdy();
    @(posedge ref_clk);
    #1;
    while (hr_q !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {26'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {16'h0000, wd};
    wait_rdy();
    rd = rd_q;
  endtask
  task automatic rdr(input logic [3:0] idx);
    bus(1'b0, idx, 16'h0000);
  endtask
  task automatic wait_fin();
    @(posedge ref_clk);
    #1;
    while (fin_q !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
  endtask
  // Low bits carry latch, polarity, zeroing and persistence; mode is single-shot.
  task automatic single(input logic [3:0] rng, input logic [4:0] lo, input logic [11:0] m,
                        input logic [3:0] ob);
    mant <= m;
    ovb <= ob;
    auto <= (rng == 4'hC);
    bus(1'b1, 4'h1, {rng, 3'b101, 4'h0, lo});
    wait_fin();
  endtask
  task automatic t_reset();
    rdr(4'h1);
    check(rd, 32'h0000_C810, "config reset");
    check({hreadyout, hresp, alert_out, conv_long}, 4'b1001, "fixed outputs");
    bus(1'b1, 4'h1, 16'hC9F0);
    rdr(4'h1);
    check(rd, 32'h0000_C810, "status writes ignored");
    rdr(4'h0);
    check(rd, 32'h0000_0000, "result reset");
    rdr(4'h3);
    check(rd, 32'h0000_BFFF, "high reset");
    rdr(4'h9);
    check(rd, 32'h0000_0000, "unmapped");
    check(alert_oe, 1'b0, "alert idle");
    $display("test reset done");
  endtask
  task automatic t_manual();
    single(4'h5, 5'b10000, 12'h123, 4'h0);
    rdr(4'h1);
    check(rd, 32'h0000_5890, "done set, mode back");
    rdr(4'h0);
    check(rd, 32'h0000_5123, "manual result");
    rdr(4'h1);
    check(rd, 32'h0000_5810, "done cleared by read");
    single(4'h5, 5'b10100, 12'h123, 4'hF);
    rdr(4'h0);
    check(rd, 32'h0000_0123, "exponent zeroed");
    single(4'h5, 5'b10100, 12'h123, 4'hF);
    bus(1'b1, 4'h1, 16'h5814);
    rdr(4'h1);
    check(rd, 32'h0000_5994, "shutdown keeps done");
    single(4'h5, 5'b10100, 12'h123, 4'hF);
    lat <= 8'h20;
    bus(1'b1, 4'h1, 16'h5A14);
    rdr(4'h1);
    check(rd, 32'h0000_5B14, "write clears done");
    wait_fin();
    lat <= 8'h03;
    $display("test manual done");
  endtask
  task automatic t_auto();
    int s0;
    s0 = starts;
    single(4'hC, 5'b10100, 12'h0AB, 4'h3);
    check(starts - s0, 4, "auto steps");
    rdr(4'h0);
    check(rd, 32'h0000_30AB, "auto range kept");
    rdr(4'h1);
    check(rd, 32'h0000_C894, "no overflow");
    s0 = starts;
    single(4'hC, 5'b10100, 12'h0AB, 4'hF);
    check(starts - s0, 12, "auto to top");
    rdr(4'h0);
    check(rd, 32'h0000_B0AB, "top range");
    rdr(4'h1);
    check(rd, 32'h0000_C994, "overflow at top");
    // Continuous mode must keep its mode code across measurements.
    ovb <= 4'h0;
    auto <= 1'b0;
    bus(1'b1, 4'h1, 16'h5C10);
    wait_fin();
    wait_fin();
    rdr(4'h1);
    check(rd, 32'h0000_5C90, "continuous keeps mode");
    bus(1'b1, 4'h1, 16'h5810);
    // Let an abandoned conversion finish so its done pulse cannot end a later wait.
    repeat (16) @(posedge ref_clk);
    $display("test auto done");
  endtask
  task automatic t_persist();
    bus(1'b1, 4'h3, 16'h0100);
    for (int p = 0; p < 4; p++)
    begin
      single(4'h0, {3'b000, p[1:0]}, 12'h050, 4'h0);
      for (int i = 1; i < (1 << p); i++)
        single(4'h0, {3'b000, p[1:0]}, 12'h200, 4'h0);
      check(alert_oe, 1'b0, "below count");
      single(4'h0, {3'b000, p[1:0]}, 12'h200, 4'h0);
      rdr(4'h1);
      check(rd[6], 1'b1, "over hit");
      check(alert_oe, 1'b1, "alert driven low");
      single(4'h0, {3'b000, p[1:0]}, 12'h050, 4'h0);
      check(alert_oe, 1'b0, "alert follows");
      rdr(4'h1);
      check(rd[6], 1'b0, "flag follows");
    end
    $display("test persistence done");
  endtask
  task automatic t_under_pol();
    bus(1'b1, 4'h2, 16'h0010);
    single(4'h0, 5'b01000, 12'h008, 4'h0);
    rdr(4'h1);
    check(rd[5], 1'b1, "under hit");
    check(alert_oe, 1'b0, "alert released");
    single(4'h5, 5'b01100, 12'h010, 4'h0);
    rdr(4'h1);
    check(rd[6:5], 2'b10, "unmasked compare");
    single(4'h0, 5'b01000, 12'h050, 4'h0);
    check(alert_oe, 1'b1, "inactive driven");
    $display("test polarity done");
  endtask
  task automatic t_latch();
    single(4'h0, 5'b10000, 12'h200, 4'h0);
    single(4'h0, 5'b10000, 12'h050, 4'h0);
    check(alert_oe, 1'b1, "latched alert");
    bus(1'b1, 4'h1, 16'h0810);
    check(alert_oe, 1'b1, "shutdown keeps alert");
    rdr(4'h1);
    check(rd[6], 1'b1, "latched flag");
    rdr(4'h1);
    check(rd[6], 1'b0, "read clears flag");
    check(alert_oe, 1'b0, "read clears alert");
    $display("test latch done");
  endtask
  initial
  begin
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    mant = 12'h000;
    ovb = 4'h0;
    lat = 8'h03;
    auto = 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    fork
      begin
        t_reset();
        t_manual();
        t_auto();
        t_persist();
        t_under_pol();
        t_latch();
      end
      begin
        wait (cycles >= 30000);
        fail_count++;
        $display("ERROR t=%0t timeout", $time);
      end
    join_any
    give_verdict();
  end
endmodule
